// file: dsg_deep_gate.sv
// What this block does
// RULE1: a set enable bit clocks its unit and a clear bit stops that unit's clock.
// RULE2: an access to a unit whose clock is off gets a bus fault instead of a normal answer.
// RULE3: reset clears the whole gating register so every unit starts unclocked.
// RULE4: run mode uses the run register, sleep the sleep register, deep sleep this register.
// RULE5: sleep and deep-sleep registers act only while auto gating select is set.
// RULE6: bits 26, 25, 24 gate comparators 2, 1, 0 and are read/write.
// RULE7: bits 19 to 16 gate timers 3 to 0 and are read/write.
// RULE8: bit 12 gates the two-wire unit and bit 8 the quadrature encoder.
// RULE9: bits 5 and 4 gate synchronous serial units 1 and 0.
// RULE10: bits 2, 1, 0 gate asynchronous serial units 2, 1, 0.
// RULE11: reserved bits are read-only zero and software keeps them on read-modify-write.
// RULE12: the register sits at offset 0x124 from base 0x400FE000.
// RULE13: software enables each unit it needs before using it.
// RULE14: writes to reserved positions change nothing; only writes to real bits or reset do.
module dsg_deep_gate
    import dsg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [31:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic      [1:0]  avs_response,
    output logic             avs_waitrequest,
    input  wire logic [1:0]  power_mode,
    input  wire logic        auto_gating_select,
    input  wire logic [31:0] run_peripheral_gate_1,
    input  wire logic [31:0] sleep_peripheral_gate_1,
    input  wire logic [31:0] periph_access,
    output logic      [31:0] periph_fault,
    output logic      [31:0] periph_clk_en,
    output logic      [31:0] periph_gclk,
    output logic             irq
);

    // ************************************************************
    // bus handshake
    // ************************************************************
    // one wait state: request seen, answer next edge
    logic        ack_ff;
    logic        req;
    logic        accept;
    logic        hit_gate;
    logic        hit_stat;
    logic        hit_en;
    logic        hit_clr;
    logic        hit_any;
    logic [31:0] byte_mask;
    logic [31:0] rd_mux;
    logic [31:0] rdata_ff;
    logic [1:0]  resp_ff;

    assign req             = avs_read | avs_write;
    assign accept          = req & ack_ff;
    assign avs_waitrequest = req & ~ack_ff;

    assign hit_gate = (avs_address == (DSG_SYSCTL_BASE + DSG_OFS_DEEP_GATE)); // RULE12
    assign hit_stat = (avs_address == (DSG_SYSCTL_BASE + DSG_OFS_IRQ_STAT));
    assign hit_en   = (avs_address == (DSG_SYSCTL_BASE + DSG_OFS_IRQ_EN));
    assign hit_clr  = (avs_address == (DSG_SYSCTL_BASE + DSG_OFS_IRQ_CLR));
    assign hit_any  = hit_gate | hit_stat | hit_en | hit_clr;

    assign byte_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ************************************************************
    // deep-sleep gating register
    // ************************************************************
    logic [31:0] deep_gate_ff;
    logic [31:0] nxt_deep_gate;
    logic [31:0] wr_mask;
    logic        gate_we;

    assign gate_we       = accept & avs_write & hit_gate;
    // only implemented, byte-enabled positions may change
    assign wr_mask       = byte_mask & DSG_GATE_IMPL; // RULE14 RULE11
    assign nxt_deep_gate = (deep_gate_ff & ~wr_mask) | (avs_writedata & wr_mask);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            deep_gate_ff <= DSG_GATE_RESET; // RULE3
        end else if (gate_we) begin
            deep_gate_ff <= nxt_deep_gate; // RULE6 RULE7 RULE8 RULE9 RULE10
        end
    end

    // ************************************************************
    // mode selection
    // ************************************************************
    logic [31:0] sel_gate;
    logic [31:0] clk_en_ff;
    logic        is_sleep;
    logic        is_deep;

    assign is_sleep = (power_mode == DSG_MODE_SLEEP);
    assign is_deep  = (power_mode == DSG_MODE_DEEP);

    // without auto gating select every mode keeps the run settings;
    // the unused mode code also falls back to run
    assign sel_gate = (is_deep && auto_gating_select)  ? deep_gate_ff :  // RULE4 RULE5
                      (is_sleep && auto_gating_select) ? sleep_peripheral_gate_1 :
                                                         run_peripheral_gate_1;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clk_en_ff <= DSG_GATE_RESET; // RULE3
        end else begin
            clk_en_ff <= sel_gate & DSG_GATE_IMPL; // RULE1
        end
    end

    assign periph_clk_en = clk_en_ff;

    // ************************************************************
    // clock gates, one per implemented bit
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < DSG_NUM_BITS; gi++) begin : g_gate
            if (DSG_GATE_IMPL[gi]) begin : g_impl
                dsg_clk_gate u_gate (
                    .core_clk  (core_clk),
                    .enable    (clk_en_ff[gi]), // RULE1
                    .gated_clk (periph_gclk[gi])
                );
            end else begin : g_none
                assign periph_gclk[gi] = 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // access faults
    // ************************************************************
    // combinational so the peripheral bus can answer in the same cycle
    assign periph_fault = periph_access & ~clk_en_ff; // RULE2

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [DSG_IRQ_BITS-1:0] irq_event;
    logic [DSG_IRQ_BITS-1:0] irq_status;
    logic [DSG_IRQ_BITS-1:0] irq_enable;
    logic                    deep_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            deep_ff <= 1'b0;
        end else begin
            deep_ff <= is_deep;
        end
    end

    assign irq_event[DSG_IRQ_POS_FAULT] = |periph_fault;
    assign irq_event[DSG_IRQ_POS_DEEP]  = is_deep & ~deep_ff;

    dsg_irq u_irq (
        .core_clk (core_clk),
        .rstn     (rstn),
        .event_in (irq_event),
        .en_we    (accept & avs_write & hit_en & avs_byteenable[0]),
        .clr_we   (accept & avs_write & hit_clr & avs_byteenable[0]),
        .wdata    (avs_writedata[DSG_IRQ_BITS-1:0]),
        .status   (irq_status),
        .enable   (irq_enable),
        .irq      (irq)
    );

    // ************************************************************
    // read path
    // ************************************************************
    // reserved bits and the write-only clear register read zero
    assign rd_mux = hit_gate ? (deep_gate_ff & DSG_GATE_IMPL) : // RULE11
                    hit_stat ? {30'h0, irq_status} :
                    hit_en   ? {30'h0, irq_enable} :
                               32'h00000000;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ack_ff   <= 1'b0;
            rdata_ff <= DSG_RDATA_RESET;
            resp_ff  <= DSG_RESP_OKAY;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req && !ack_ff) begin
                rdata_ff <= avs_read ? rd_mux : DSG_RDATA_RESET;
                resp_ff  <= hit_any ? DSG_RESP_OKAY : DSG_RESP_DECERR;
            end
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_response = resp_ff;

endmodule

// file: dsg_pkg.sv
package dsg_pkg;

    // ************************************************************
    // bus map
    // ************************************************************
    localparam logic [31:0] DSG_SYSCTL_BASE   = 32'h400FE000;
    localparam logic [31:0] DSG_OFS_DEEP_GATE = 32'h00000124;
    localparam logic [31:0] DSG_OFS_IRQ_STAT  = 32'h00000200;
    localparam logic [31:0] DSG_OFS_IRQ_EN    = 32'h00000204;
    localparam logic [31:0] DSG_OFS_IRQ_CLR   = 32'h00000208;

    // ************************************************************
    // gating register layout
    // ************************************************************
    localparam int          DSG_NUM_BITS      = 32;
    localparam logic [31:0] DSG_GATE_RESET    = 32'h00000000;
    localparam logic [31:0] DSG_GATE_IMPL     = 32'h070F1137;
    localparam int          DSG_POS_CMP_2     = 26;
    localparam int          DSG_POS_CMP_1     = 25;
    localparam int          DSG_POS_CMP_0     = 24;
    localparam int          DSG_POS_GPTM_3    = 19;
    localparam int          DSG_POS_GPTM_2    = 18;
    localparam int          DSG_POS_GPTM_1    = 17;
    localparam int          DSG_POS_GPTM_0    = 16;
    localparam int          DSG_POS_TWI_0     = 12;
    localparam int          DSG_POS_QUAD_0    = 8;
    localparam int          DSG_POS_SSER_1    = 5;
    localparam int          DSG_POS_SSER_0    = 4;
    localparam int          DSG_POS_ASER_2    = 2;
    localparam int          DSG_POS_ASER_1    = 1;
    localparam int          DSG_POS_ASER_0    = 0;

    // ************************************************************
    // interrupt layout
    // ************************************************************
    localparam int          DSG_IRQ_BITS      = 2;
    localparam int          DSG_IRQ_POS_FAULT = 0;
    localparam int          DSG_IRQ_POS_DEEP  = 1;
    localparam logic [1:0]  DSG_IRQ_RESET     = 2'h0;

    // ************************************************************
    // bus answers
    // ************************************************************
    localparam logic [1:0]  DSG_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  DSG_RESP_DECERR   = 2'h3;
    localparam logic [31:0] DSG_RDATA_RESET   = 32'h00000000;

    typedef enum logic [1:0] {
        DSG_MODE_RUN   = 2'b00,
        DSG_MODE_SLEEP = 2'b01,
        DSG_MODE_DEEP  = 2'b10
    } dsg_mode_e;

endpackage

// file: dsg_clk_gate.sv
module dsg_clk_gate
    import dsg_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic enable,
    output wire logic gated_clk
);

    // ************************************************************
    // glitch-free gate
    // ************************************************************
    // enable is latched while the clock is low so a change can never
    // chop a high phase short
    logic en_lat;

    always_latch begin
        if (!core_clk) begin
            en_lat <= enable;
        end
    end

    assign gated_clk = core_clk & en_lat;

endmodule

// file: dsg_irq.sv
module dsg_irq
    import dsg_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    input  wire logic [DSG_IRQ_BITS-1:0] event_in,
    input  wire logic                    en_we,
    input  wire logic                    clr_we,
    input  wire logic [DSG_IRQ_BITS-1:0] wdata,
    output logic      [DSG_IRQ_BITS-1:0] status,
    output logic      [DSG_IRQ_BITS-1:0] enable,
    output logic                         irq
);

    logic [DSG_IRQ_BITS-1:0] status_ff;
    logic [DSG_IRQ_BITS-1:0] enable_ff;
    logic [DSG_IRQ_BITS-1:0] nxt_status;
    logic [DSG_IRQ_BITS-1:0] clr_mask;

    // set beats clear when both land in one cycle
    assign clr_mask   = clr_we ? wdata : '0;
    assign nxt_status = (status_ff & ~clr_mask) | event_in;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_ff <= DSG_IRQ_RESET;
            enable_ff <= DSG_IRQ_RESET;
        end else begin
            status_ff <= nxt_status;
            if (en_we) begin
                enable_ff <= wdata;
            end
        end
    end

    assign status = status_ff;
    assign enable = enable_ff;
    assign irq    = |(status_ff & enable_ff);

endmodule

// file: dsg_deep_gate_chk.sv
module dsg_deep_gate_chk
    import dsg_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic [31:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0]  avs_response,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  power_mode,
    input wire logic        auto_gating_select,
    input wire logic [31:0] run_peripheral_gate_1,
    input wire logic [31:0] sleep_peripheral_gate_1,
    input wire logic [31:0] periph_access,
    input wire logic [31:0] periph_fault,
    input wire logic [31:0] periph_clk_en,
    input wire logic        irq
);
    // ************************************************************
    // port relations
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire        take   = (avs_read | avs_write) & ~avs_waitrequest;
    wire [31:0] ofs    = avs_address - DSG_SYSCTL_BASE;
    wire        hit    = ofs == DSG_OFS_DEEP_GATE;
    wire        mapped = ofs inside {DSG_OFS_DEEP_GATE, DSG_OFS_IRQ_STAT,
                                     DSG_OFS_IRQ_EN, DSG_OFS_IRQ_CLR};
    wire        runsel = !auto_gating_select || power_mode == 2'h0 || power_mode == 2'h3;
    property p_wait;
        (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_fault;
        periph_fault == (periph_access & ~periph_clk_en);
    endproperty
    property p_mask;
        (periph_clk_en & ~DSG_GATE_IMPL) == 32'h0;
    endproperty
    // reset must be seen even though everything else is disabled by it
    property p_reset;
        disable iff (1'b0) !rstn |=> periph_clk_en == 32'h0;
    endproperty
    property p_run;
        runsel |=> periph_clk_en == ($past(run_peripheral_gate_1) & DSG_GATE_IMPL);
    endproperty
    property p_sleep;
        auto_gating_select && power_mode == 2'h1
            |=> periph_clk_en == ($past(sleep_peripheral_gate_1) & DSG_GATE_IMPL);
    endproperty
    property p_rd;
        avs_read && take && hit |-> (avs_readdata & ~DSG_GATE_IMPL) == 32'h0
            && avs_response == DSG_RESP_OKAY;
    endproperty
    property p_unmapped;
        take && !mapped |-> avs_response == DSG_RESP_DECERR && avs_readdata == 32'h0;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state not one cycle");
    a_fault: assert property (p_fault) else $error("fault mismatch");
    a_mask: assert property (p_mask) else $error("reserved enable set");
    a_reset: assert property (p_reset) else $error("enables not cleared");
    a_run: assert property (p_run) else $error("run selection wrong");
    a_sleep: assert property (p_sleep) else $error("sleep selection wrong");
    a_rd: assert property (p_rd) else $error("reserved read nonzero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    c_deep: cover property (power_mode == 2'h2 && auto_gating_select && periph_clk_en != 32'h0);
    c_fault: cover property (periph_fault != 32'h0);
    c_irq: cover property (irq);
endmodule

bind dsg_deep_gate dsg_deep_gate_chk u_chk (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .power_mode(power_mode),
    .auto_gating_select(auto_gating_select), .run_peripheral_gate_1(run_peripheral_gate_1),
    .sleep_peripheral_gate_1(sleep_peripheral_gate_1), .periph_access(periph_access),
    .periph_fault(periph_fault), .periph_clk_en(periph_clk_en), .irq(irq));

// file: dsg_periph_model.sv
module dsg_periph_model (
    input  wire logic [31:0] periph_gclk,
    input  wire logic [31:0] periph_fault,
    input  wire logic [31:0] access_req,
    input  wire logic        core_clk,
    output logic      [31:0] periph_access,
    output int               fault_cnt,
    output int               ticks [32]
);
    // ************************************************************
    // gated units: count their clock edges and refused accesses
    // ************************************************************
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fault_cnt = 0;
        periph_access = 32'h0;
    end
    always @(posedge core_clk) begin
        periph_access <= access_req;
        if (|periph_fault) begin
            fault_cnt <= fault_cnt + 1;
        end
    end
    for (genvar i = 0; i < 32; i++) begin : g_unit
        int n = 0;
        always @(posedge periph_gclk[i]) begin
            n <= n + 1;
        end
        assign ticks[i] = n;
    end
endmodule

// file: deep_sleep_clock_gating_1_tb_top.sv
module deep_sleep_clock_gating_1_tb_top
    import dsg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
    // ************************************************************
    // stimulus and checks
    // ************************************************************
    localparam logic [31:0] GA = DSG_SYSCTL_BASE + DSG_OFS_DEEP_GATE;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        auto_gating_select = 1'b0;
    logic [1:0]  power_mode = 2'h0;
    logic [31:0] avs_address = 32'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] run_peripheral_gate_1 = 32'h0;
    logic [31:0] sleep_peripheral_gate_1 = 32'h0;
    logic [31:0] acc_req = 32'h0;
    wire  [31:0] avs_readdata, periph_access, periph_fault, periph_clk_en, periph_gclk;
    wire  [1:0]  avs_response;
    wire         avs_waitrequest, irq;
    int          ticks [32];
    int          fault_cnt, t0, t4;
    int          err_total = 0;
    int          comparisons = 0;
    logic [31:0] q;
    logic [31:0] ex;
    logic [3:0]  be = 4'hF;
    logic [1:0]  r;
    logic [1:0]  m_t [6] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h2, 2'h2};
    logic        a_t [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] e_t [6] = '{32'h070F0000, 32'h00001137, 32'h070F0000, 32'h070F0000,
                             32'h070F0000, 32'h00000007};
    always #5 core_clk = ~core_clk;
    dsg_deep_gate dut (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_response,
        .avs_waitrequest, .power_mode, .auto_gating_select, .run_peripheral_gate_1,
        .sleep_peripheral_gate_1, .periph_access, .periph_fault, .periph_clk_en,
        .periph_gclk, .irq);
    dsg_periph_model u_far (.periph_gclk, .periph_fault, .access_req(acc_req), .core_clk,
        .periph_access, .fault_cnt, .ticks);
    // request held until waitrequest is seen low at a rising edge; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic pulse(input int cycles);
        @(posedge core_clk);
        acc_req <= 32'h01000000;
        @(posedge core_clk);
        acc_req <= 32'h0;
        repeat (cycles) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task complete_run;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #50us;
        err_total++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        bus(1'b0, GA, 32'h0);
        `CHK("gate after reset", 32'h0, q)
        `CHK("enables after reset", 32'h0, periph_clk_en)
        for (int i = 0; i < 32; i++) begin
            bus(1'b1, GA, 32'h1 << i);
            bus(1'b0, GA, 32'h0);
            ex = (32'h1 << i) & DSG_GATE_IMPL;
            `CHK("gate bit", ex, q)
        end
        // unit still unclocked in run mode: access must be refused
        bus(1'b1, DSG_SYSCTL_BASE + DSG_OFS_IRQ_EN, 32'h1);
        pulse(3);
        `CHK("fault count", 1, fault_cnt)
        `CHK("irq enabled", 1'b1, irq)
        bus(1'b1, DSG_SYSCTL_BASE + DSG_OFS_IRQ_CLR, 32'h1);
        bus(1'b0, DSG_SYSCTL_BASE + DSG_OFS_IRQ_STAT, 32'h0);
        `CHK("status cleared", 32'h0, q)
        bus(1'b1, DSG_SYSCTL_BASE + DSG_OFS_IRQ_EN, 32'h0);
        pulse(3);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b0, DSG_SYSCTL_BASE + DSG_OFS_IRQ_STAT, 32'h0);
        `CHK("status sticky", 32'h1, q)
        @(posedge core_clk);
        run_peripheral_gate_1 <= 32'hFFFF0000;
        sleep_peripheral_gate_1 <= 32'h0000FFFF;
        bus(1'b1, GA, 32'h7);
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            power_mode <= m_t[k];
            auto_gating_select <= a_t[k];
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            `CHK("mode enables", e_t[k], periph_clk_en)
        end
        t0 = ticks[0];
        t4 = ticks[4];
        repeat (5) @(negedge core_clk);
        `CHK("clocked unit edges", 5, ticks[0] - t0)
        `CHK("stopped unit edges", 0, ticks[4] - t4)
        // only the top lane is enabled: the low enables must survive
        @(posedge core_clk);
        be <= 4'h8;
        bus(1'b1, GA, 32'hFFFFFFFF);
        @(posedge core_clk);
        be <= 4'hF;
        bus(1'b0, GA, 32'h0);
        `CHK("lane write", 32'h07000007, q)
        bus(1'b0, DSG_SYSCTL_BASE + 32'h300, 32'h0);
        `CHK("unmapped response", DSG_RESP_DECERR, r)
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        bus(1'b0, GA, 32'h0);
        `CHK("gate after second reset", 32'h0, q)
        `CHK("enables after second reset", 32'h0, periph_clk_en)
        complete_run;
    end
endmodule
